// *** rtl/urb_baud_div.sv ***
// Fractional baud divider producing a 16x sampling tick with optional prescaler.
`timescale 1ns/1ps
module urb_baud_div (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] div_int_i,
	input  wire logic [3:0]  div_frac_i,
	input  wire logic        prescale_i,
	output logic             tick16_o
);
	// ==========================================================
	// Divider
	logic [15:0] cnt;
	logic [3:0]  acc;
	logic [1:0]  pre;
	wire  [15:0] div_eff   = (div_int_i == 16'h0000) ? 16'h0001 : div_int_i;
	wire  [4:0]  frac_sum  = {1'b0, acc} + {1'b0, div_frac_i};
	wire         raw_tick  = (cnt <= 16'h0001);
	wire  [15:0] next_cnt  = raw_tick ? div_eff + {15'h0000, frac_sum[4]} : cnt - 16'h0001;
	wire         pre_wrap  = (pre == 2'(urb_pkg::PRESCALE_DIV - 1));
	// The fraction only stretches a period by one cycle, so jitter stays within one input clock.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt      <= 16'h0001;
			acc      <= 4'h0;
			pre      <= 2'h0;
			tick16_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			if (raw_tick) begin
				acc <= frac_sum[3:0];
				pre <= pre + 2'h1;
			end
			tick16_o <= raw_tick && (!prescale_i || pre_wrap);
		end
	end
endmodule : urb_baud_div

// *** rtl/urb_chan_ctrl.sv ***
// Four-channel UART ready, interrupt and baud clock logic with a Wishbone register slave.
`timescale 1ns/1ps
module urb_chan_ctrl (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [6:0]       adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	input  wire logic [3:0][4:0]  rx_level_i,
	input  wire logic [3:0]       rx_push_i,
	input  wire logic [3:0][4:0]  tx_level_i,
	input  wire logic [3:0]       tx_shift_empty_i,
	output logic      [3:0]       int_o,
	output logic      [3:0]       rx_avail_n_o,
	output logic      [3:0]       tx_room_n_o,
	output logic      [3:0]       tick16_o
);
	localparam int N = urb_pkg::NUM_CH;

	// ==========================================================
	// Helpers
	function automatic logic [9:0] tmo_limit(input logic [1:0] wl);
		int bits;
		bits = urb_pkg::TMO_CHARS * (urb_pkg::BASE_WORD_BITS + int'(wl)) + urb_pkg::TMO_EXTRA_BITS;
		tmo_limit = 10'(bits * urb_pkg::TICKS_PER_BIT);
	endfunction : tmo_limit

	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction : byte_word

	// ==========================================================
	// Register storage
	logic [7:0] fifo_ctrl    [N];
	logic [1:0] line_ctrl    [N];
	logic [7:0] modem_ctrl   [N];
	logic [7:0] divisor_low  [N];
	logic [7:0] divisor_high [N];
	logic [3:0] divisor_frac [N];
	logic [4:0] rx_trig      [N];
	logic [9:0] tmo_cnt      [N];
	logic [3:0] tmo_flag;
	logic [3:0] rx_blk_n;

	// ==========================================================
	// Bus decode
	wire        bus_req   = cyc_i && stb_i && !ack_o;
	wire        wr_lane   = bus_req && we_i && sel_i[0];
	wire  [1:0] acc_ch    = adr_i[6:5];
	wire  [2:0] acc_idx   = adr_i[4:2];
	wire  [7:0] wr_byte   = dat_i[7:0];
	wire        addr_ok   = (adr_i[1:0] == 2'h0);

	// ==========================================================
	// Per-channel status decode
	logic [3:0] fifo_on;
	logic [3:0] block_on;
	logic [3:0] rx_any;
	logic [3:0] rx_at_trig;
	logic [3:0] tx_empty;
	logic [3:0] tx_full;
	logic [3:0] tx_below;
	logic [3:0] tx_all_empty;
	logic [3:0] tmo_hit;
	logic [7:0] line_stat [N];

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_dec
			assign fifo_on[g]      = fifo_ctrl[g][urb_pkg::FC_FIFO_EN];
			assign block_on[g]     = fifo_on[g] && fifo_ctrl[g][urb_pkg::FC_BLOCK];
			assign rx_any[g]       = (rx_level_i[g] != 5'h00);
			assign rx_at_trig[g]   = (rx_level_i[g] >= rx_trig[g]);
			assign tx_empty[g]     = (tx_level_i[g] == 5'h00);
			assign tx_full[g]      = (tx_level_i[g] >= urb_pkg::FIFO_FULL);
			assign tx_below[g]     = (tx_level_i[g] < urb_pkg::TX_TRIG_LVL);
			assign tx_all_empty[g] = tx_empty[g] && tx_shift_empty_i[g];
			assign tmo_hit[g]      = (tmo_cnt[g] >= tmo_limit(line_ctrl[g]));
			assign line_stat[g]    = {tmo_flag[g], tx_all_empty[g], tx_empty[g], 4'h0, rx_any[g]};
		end
	endgenerate

	// ==========================================================
	// Baud dividers, one per channel
	generate
		for (g = 0; g < N; g++) begin : g_baud
			urb_baud_div u_div (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.div_int_i  ({divisor_high[g], divisor_low[g]}),
				.div_frac_i (divisor_frac[g]),
				.prescale_i (modem_ctrl[g][urb_pkg::MC_PRESCALE]),
				.tick16_o   (tick16_o[g])
			);
		end
	endgenerate

	// ==========================================================
	// Register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < N; c++) begin
				fifo_ctrl[c]    <= urb_pkg::FIFO_CTRL_RST;
				line_ctrl[c]    <= urb_pkg::LINE_CTRL_RST;
				modem_ctrl[c]   <= 8'h00;
				divisor_low[c]  <= urb_pkg::DIV_LOW_RST;
				divisor_high[c] <= urb_pkg::DIV_HIGH_RST;
				divisor_frac[c] <= urb_pkg::DIV_FRAC_RST;
				rx_trig[c]      <= urb_pkg::RX_TRIG_RST;
			end
		end else if (wr_lane && addr_ok) begin
			case (acc_idx)
				urb_pkg::IDX_FIFO_CTRL:  fifo_ctrl[acc_ch]    <= wr_byte;
				urb_pkg::IDX_LINE_CTRL:  line_ctrl[acc_ch]    <= wr_byte[1:0];
				urb_pkg::IDX_MODEM_CTRL: modem_ctrl[acc_ch]   <= wr_byte;
				urb_pkg::IDX_DIV_LOW:    divisor_low[acc_ch]  <= wr_byte;
				urb_pkg::IDX_DIV_HIGH:   divisor_high[acc_ch] <= wr_byte;
				urb_pkg::IDX_DIV_FRAC:   divisor_frac[acc_ch] <= wr_byte[3:0];
				urb_pkg::IDX_RX_TRIG:    rx_trig[acc_ch]      <= wr_byte[4:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux and acknowledge
	logic [31:0] next_dat;
	always_comb begin
		next_dat = 32'h00000000;
		if (addr_ok) begin
			case (acc_idx)
				urb_pkg::IDX_FIFO_CTRL:  next_dat = byte_word(fifo_ctrl[acc_ch]);
				urb_pkg::IDX_LINE_CTRL:  next_dat = byte_word({6'h00, line_ctrl[acc_ch]});
				urb_pkg::IDX_MODEM_CTRL: next_dat = byte_word(modem_ctrl[acc_ch]);
				urb_pkg::IDX_DIV_LOW:    next_dat = byte_word(divisor_low[acc_ch]);
				urb_pkg::IDX_DIV_HIGH:   next_dat = byte_word(divisor_high[acc_ch]);
				urb_pkg::IDX_DIV_FRAC:   next_dat = byte_word({4'h0, divisor_frac[acc_ch]});
				urb_pkg::IDX_LINE_STAT:  next_dat = byte_word(line_stat[acc_ch]);
				urb_pkg::IDX_RX_TRIG:    next_dat = byte_word({3'h0, rx_trig[acc_ch]});
				default:                 next_dat = 32'h00000000;
			endcase
		end
	end

	// Every access is answered one cycle after it is seen; misaligned ones read zero and write nothing.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= bus_req;
			if (bus_req && !we_i) begin
				dat_o <= next_dat;
			end
		end
	end

	// ==========================================================
	// Receive timeout, counted in 16x ticks while data waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < N; c++) begin
				tmo_cnt[c] <= 10'h000;
			end
			tmo_flag <= 4'h0;
		end else begin
			for (int c = 0; c < N; c++) begin
				if (!rx_any[c] || rx_push_i[c]) begin
					tmo_cnt[c] <= 10'h000;
				end else if (tick16_o[c] && !tmo_hit[c]) begin
					tmo_cnt[c] <= tmo_cnt[c] + 10'h001;
				end
				tmo_flag[c] <= tmo_hit[c] && rx_any[c] && !rx_push_i[c];
			end
		end
	end

	// ==========================================================
	// Block-mode receive-ready latch
	// A falling edge needs trigger or timeout, but only an empty FIFO releases it, so a
	// host reading below the trigger still sees the pin held until the block is drained.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_blk_n <= 4'hF;
		end else begin
			for (int c = 0; c < N; c++) begin
				if (!rx_any[c]) begin
					rx_blk_n[c] <= 1'b1;
				end else if (rx_at_trig[c] || tmo_flag[c]) begin
					rx_blk_n[c] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Pin and interrupt outputs
	logic [3:0] next_int;
	logic [3:0] next_rx_n;
	logic [3:0] next_tx_n;
	logic [3:0] tx_int;
	logic [3:0] rx_int;

	generate
		for (g = 0; g < N; g++) begin : g_pin
			assign tx_int[g]    = fifo_on[g] ? tx_below[g] : tx_empty[g];
			assign rx_int[g]    = fifo_on[g] ? (rx_at_trig[g] || tmo_flag[g]) : rx_any[g];
			assign next_int[g]  = tx_int[g] || rx_int[g];
			assign next_rx_n[g] = block_on[g] ? rx_blk_n[g] : !rx_any[g];
			assign next_tx_n[g] = block_on[g] ? tx_full[g] : !tx_empty[g];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_o        <= 4'h0;
			rx_avail_n_o <= 4'hF;
			tx_room_n_o  <= 4'hF;
		end else begin
			int_o        <= next_int;
			rx_avail_n_o <= next_rx_n;
			tx_room_n_o  <= next_tx_n;
		end
	end
endmodule : urb_chan_ctrl

// *** shared/urb_pkg.sv ***
// Constants shared by the channel signalling and baud divider logic.
package urb_pkg;
	// ==========================================================
	// Geometry
	localparam int          NUM_CH       = 4;
	localparam int          FIFO_DEPTH   = 16;
	localparam int          LVL_W        = 5;
	localparam logic [4:0]  FIFO_FULL    = 5'h10;
	localparam logic [4:0]  TX_TRIG_LVL  = 5'h08;
	// ==========================================================
	// Register word index within a channel (byte address = ch*0x20 + idx*4)
	localparam logic [2:0]  IDX_FIFO_CTRL = 3'h0;
	localparam logic [2:0]  IDX_LINE_CTRL = 3'h1;
	localparam logic [2:0]  IDX_MODEM_CTRL = 3'h2;
	localparam logic [2:0]  IDX_DIV_LOW   = 3'h3;
	localparam logic [2:0]  IDX_DIV_HIGH  = 3'h4;
	localparam logic [2:0]  IDX_DIV_FRAC  = 3'h5;
	localparam logic [2:0]  IDX_LINE_STAT = 3'h6;
	localparam logic [2:0]  IDX_RX_TRIG   = 3'h7;
	// ==========================================================
	// Field positions
	localparam int          FC_FIFO_EN   = 0;
	localparam int          FC_BLOCK     = 3;
	localparam int          MC_PRESCALE  = 7;
	localparam int          LS_DATA_RDY  = 0;
	localparam int          LS_TX_ROOM   = 5;
	localparam int          LS_TX_EMPTY  = 6;
	localparam int          LS_RX_TMO    = 7;
	// ==========================================================
	// Reset values
	localparam logic [7:0]  DIV_LOW_RST  = 8'h01;
	localparam logic [7:0]  DIV_HIGH_RST = 8'h00;
	localparam logic [3:0]  DIV_FRAC_RST = 4'h0;
	localparam logic [7:0]  FIFO_CTRL_RST = 8'h00;
	localparam logic [1:0]  LINE_CTRL_RST = 2'h0;
	localparam logic [4:0]  RX_TRIG_RST  = 5'h01;
	// ==========================================================
	// Receive timeout: four characters plus twelve bit times, in 16x ticks
	localparam int          TMO_CHARS    = 4;
	localparam int          TMO_EXTRA_BITS = 12;
	localparam int          BASE_WORD_BITS = 5;
	localparam int          TICKS_PER_BIT = 16;
	localparam int          PRESCALE_DIV = 4;
	localparam int          TMO_W        = 10;
endpackage : urb_pkg

// *** test/testbench.sv ***
// Self-checking bench for the channel signalling and baud block.
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals and helpers
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [6:0] adr_i;
	logic [3:0] sel_i, rx_push, tx_se, int_o, rx_avail_n_o, tx_room_n_o, tick16_o;
	logic [31:0] dat_i, dat_o, q;
	logic [3:0][4:0] rx_lvl, tx_lvl;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	urb_chan_ctrl urb_chan_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_level_i(rx_lvl),
		.rx_push_i(rx_push), .tx_level_i(tx_lvl), .tx_shift_empty_i(tx_se), .int_o(int_o),
		.rx_avail_n_o(rx_avail_n_o), .tx_room_n_o(tx_room_n_o), .tick16_o(tick16_o));
	urb_fifo_model urb_fifo_model_inst (.clk_i(clk_i), .rx_level_o(rx_lvl), .rx_push_o(rx_push),
		.tx_level_o(tx_lvl), .tx_shift_empty_o(tx_se));
	task test_done;
		$display("Mismatches %0d, checks %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			test_done;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wb(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
	endtask : wb
	// Outputs settle within three edges, block-mode latch included.
	task st(input int ch, input logic [4:0] rx, input logic [4:0] tx, input logic se);
		@(posedge clk_i);
		urb_fifo_model_inst.set(ch, rx, tx, se);
		repeat (3) @(posedge clk_i);
	endtask : st
	task gap(input int ch, input int exp);
		int n;
		n = 0;
		do @(posedge clk_i); while (tick16_o[ch] !== 1'h1);
		do begin
			@(posedge clk_i);
			n++;
		end while (tick16_o[ch] !== 1'h1);
		chk(32'(n), 32'(exp));
	endtask : gap
	function logic [31:0] pins;
		return {29'h0, int_o[0], rx_avail_n_o[0], tx_room_n_o[0]};
	endfunction : pins
	// ==========================================================
	// Scenarios
	task t_defaults;
		wb(1'h0, 7'h2C, 8'h00);
		chk(q, 32'h01);
		wb(1'h0, 7'h30, 8'h00);
		chk(q, 32'h00);
		wb(1'h0, 7'h2D, 8'h00);
		chk(q, 32'h00);
		gap(1, 1);
	endtask : t_defaults
	task t_plain;
		st(0, 5'h01, 5'h00, 1'h1);
		chk(pins(), 32'h4);
		wb(1'h0, 7'h18, 8'h00);
		chk(q, 32'h61);
		st(0, 5'h00, 5'h01, 1'h0);
		chk(pins(), 32'h3);
		wb(1'h0, 7'h18, 8'h00);
		chk(q, 32'h00);
	endtask : t_plain
	task t_single;
		wb(1'h1, 7'h00, 8'h01);
		wb(1'h1, 7'h1C, 8'h04);
		st(0, 5'h03, 5'h08, 1'h0);
		chk(pins(), 32'h1);
		st(0, 5'h04, 5'h00, 1'h1);
		chk(pins(), 32'h4);
		st(0, 5'h00, 5'h07, 1'h1);
		chk(pins(), 32'h7);
	endtask : t_single
	task t_block;
		wb(1'h1, 7'h00, 8'h09);
		st(0, 5'h03, 5'h09, 1'h0);
		chk(pins(), 32'h2);
		st(0, 5'h04, 5'h10, 1'h0);
		chk(pins(), 32'h5);
		st(0, 5'h02, 5'h0F, 1'h0);
		chk(pins(), 32'h0);
		st(0, 5'h00, 5'h08, 1'h1);
		chk(pins(), 32'h2);
	endtask : t_block
	// Channel 0 stays in block mode with trigger 4, so only the timeout can pull the pin low here.
	task t_tmo;
		st(0, 5'h02, 5'h08, 1'h1);
		chk(pins(), 32'h2);
		repeat (400) @(posedge clk_i);
		chk(pins(), 32'h2);
		repeat (200) @(posedge clk_i);
		chk(pins(), 32'h4);
		wb(1'h0, 7'h18, 8'h00);
		chk(q, 32'h81);
		st(0, 5'h00, 5'h08, 1'h1);
		chk(pins(), 32'h2);
	endtask : t_tmo
	task t_baud;
		wb(1'h1, 7'h4C, 8'h03);
		gap(2, 3);
		gap(3, 1);
		wb(1'h1, 7'h48, 8'h80);
		gap(2, 12);
		wb(1'h1, 7'h4C, 8'h00);
		wb(1'h1, 7'h50, 8'h01);
		wb(1'h1, 7'h48, 8'h00);
		gap(2, 256);
	endtask : t_baud
	initial begin
		rst_i = 1'h1;
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		adr_i = 7'h00;
		sel_i = 4'h1;
		dat_i = 32'h0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		t_defaults;
		t_plain;
		t_single;
		t_block;
		t_tmo;
		t_baud;
		test_done;
	end
endmodule : testbench

// *** test/urb_chan_asserts.sv ***
// Port-level checks for the channel signalling and baud block.
`timescale 1ns/1ps
module urb_chan_asserts (
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire logic            cyc_i,
	input wire logic            stb_i,
	input wire logic            we_i,
	input wire logic [3:0][4:0] rx_level_i,
	input wire logic [3:0][4:0] tx_level_i,
	input wire logic [31:0]     dat_o,
	input wire logic            ack_o,
	input wire logic [3:0]      int_o,
	input wire logic [3:0]      rx_avail_n_o,
	input wire logic [3:0]      tx_room_n_o,
	input wire logic [3:0]      tick16_o
);
	// ==========================================================
	// Checks
	// Until the first write the channels keep their reset setup, so the plain mapping must hold.
	logic wr_seen;
	logic g;
	assign g = !rst_i && !wr_seen && !(cyc_i && stb_i && we_i);
	always_ff @(posedge clk_i) begin
		wr_seen <= rst_i ? 1'h0 : (wr_seen | (cyc_i & stb_i & we_i));
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
	ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
	dat_high_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read high bits set");
	rst_out_a: assert property ($fell(rst_i) |-> int_o == 4'h0 && rx_avail_n_o == 4'hF && tx_room_n_o == 4'hF
		&& tick16_o == 4'h0) else $error("outputs not at reset level");
	int_plain_a: assert property (g |=> int_o[0] == $past(tx_level_i[0] == 5'h0 || rx_level_i[0] != 5'h0))
		else $error("interrupt wrong");
	rx_plain_a: assert property (g |=> rx_avail_n_o[1] == $past(rx_level_i[1] == 5'h0))
		else $error("receive ready wrong");
	tx_plain_a: assert property (g |=> tx_room_n_o[2] == $past(tx_level_i[2] != 5'h0))
		else $error("transmit ready wrong");
	tick_def_a: assert property (g && $past(g) |=> tick16_o == 4'hF)
		else $error("default tick rate wrong");
	cover property (ack_o && $past(we_i));
	cover property (!rx_avail_n_o[0] && !int_o[0]);
	cover property (tx_room_n_o[0] && int_o[0]);
endmodule : urb_chan_asserts
bind urb_chan_ctrl urb_chan_asserts urb_chan_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .rx_level_i(rx_level_i), .tx_level_i(tx_level_i), .dat_o(dat_o),
	.ack_o(ack_o), .int_o(int_o), .rx_avail_n_o(rx_avail_n_o), .tx_room_n_o(tx_room_n_o), .tick16_o(tick16_o));

// *** test/urb_fifo_model.sv ***
// Serial-side FIFO status model feeding the signalling block.
`timescale 1ns/1ps
module urb_fifo_model (
	input  wire logic       clk_i,
	output logic [3:0][4:0] rx_level_o,
	output logic [3:0]      rx_push_o,
	output logic [3:0][4:0] tx_level_o,
	output logic [3:0]      tx_shift_empty_o
);
	// ==========================================================
	// State
	// A push pulse marks every rise of the receive fill, as a real receiver would.
	logic [3:0][4:0] prev_rx;
	initial begin
		rx_level_o = '0;
		tx_level_o = '0;
		tx_shift_empty_o = 4'hF;
	end
	always @(posedge clk_i) prev_rx <= rx_level_o;
	for (genvar i = 0; i < 4; i++) begin : g_push
		assign rx_push_o[i] = rx_level_o[i] > prev_rx[i];
	end
	task set(input int ch, input logic [4:0] rx, input logic [4:0] tx, input logic se);
		rx_level_o[ch] <= rx;
		tx_level_o[ch] <= tx;
		tx_shift_empty_o[ch] <= se;
	endtask : set
endmodule : urb_fifo_model
